// ---- lsc_pkg.sv ----
package lsc_pkg;

    // register offsets inside the device's own 32-byte page
    localparam logic [4:0] OFS_HS_MODE     = 5'h00;
    localparam logic [4:0] OFS_AUX_MODE    = 5'h04;
    localparam logic [4:0] OFS_RX_SETTINGS = 5'h08;
    localparam logic [4:0] OFS_TERM_PULSE  = 5'h0C;
    localparam logic [4:0] OFS_INPUT_EQ_LEVEL_SELECT       = 5'h10;
    localparam logic [4:0] OFS_TX_SETTINGS = 5'h14;
    localparam logic [4:0] OFS_STATUS      = 5'h18;

    // field positions
    localparam int MODE_POS      = 0;
    localparam int CHAN_POS      = 4;
    localparam int TERM_OFF_POS  = 0;
    localparam int TX_TERM_POS   = 0;
    localparam int TX_OCL_POS    = 1;
    localparam int ST_LOCK_POS   = 0;
    localparam int ST_PULSE_POS  = 1;
    localparam int ST_CONN_POS   = 4;
    localparam int ST_CONN_W     = 16;

    localparam int NUM_INPUTS    = 16;
    localparam int NUM_OUTPUTS   = 4;
    localparam int NUM_EQ        = 8;

    // termination disconnect pulse after a source switch
    localparam longint CLK_HZ           = 64'd100_000_000;
    localparam longint TERM_PULSE_MS    = 64'd100;
    localparam longint TERM_PULSE_CYC_L = (TERM_PULSE_MS * CLK_HZ) / 64'd1000;
    localparam int     PULSE_CNT_W      = 24;

    typedef enum logic [1:0] {
        MODE_QUAD   = 2'b00,
        MODE_DUAL   = 2'b01,
        MODE_SINGLE = 2'b10
    } lsc_mode_type;

    // parallel pins as seen after synchronisation
    typedef struct packed {
        logic [1:0] src_sel;
        logic       eq_level;
        logic       out_term;
        logic       out_cur;
        logic [2:0] slave_addr;
    } lsc_pins_type;

    typedef struct packed {
        lsc_mode_type hs_mode;
        logic [3:0]   hs_chan;
        lsc_mode_type aux_mode;
        logic [3:0]   aux_chan;
        logic         term_global_off;
        logic [15:0]  term_pulse_en;
        logic [7:0]   eq_level;
        logic         tx_term;
        logic         tx_ocl;
    } lsc_cfg_type;

    localparam lsc_cfg_type CFG_RESET = '{
        hs_mode:         MODE_QUAD,
        hs_chan:         4'h0,
        aux_mode:        MODE_QUAD,
        aux_chan:        4'h0,
        term_global_off: 1'b0,
        term_pulse_en:   16'h0000,
        eq_level:        8'h00,
        tx_term:         1'b0,
        tx_ocl:          1'b0
    };

    typedef struct packed {
        lsc_pins_type           pin_meta;
        lsc_pins_type           pin_sync;
        lsc_cfg_type            cfg;
        logic                   serial_locked;
        logic                   strap_pending;
        logic [PULSE_CNT_W-1:0] pulse_cnt;
        logic [15:0]            last_route;
        logic [31:0]            prdata;
        logic                   pslverr;
    } lsc_state_type;

    // route word: four 4-bit input indices, output 0 in the low nibble
    typedef logic [15:0] lsc_route_type;

endpackage

// ---- lsc_top.sv ----
// What this block does
// R1 - in link mode exactly one of four sources reaches the output link
// R2 - three arrangements: quad 4:1, dual 8:1, single 16:1
// R3 - all four channels of a link are routed alike, no special clock path
// R4 - control comes from parallel pins or the serial register interface
// R5 - answers only at one of eight strap-selected slave addresses
// R6 - reset returns every control register to its default
// R7 - serially written values override earlier parallel pin settings
// R8 - after any serial access parallel pins are ignored until reset
// R9 - serial control offers all arrangements, link and aux set independently
// R10 - parallel control: quad only, one 2-bit bus selects link and aux
// R11 - enabled inputs lose termination for about 100 ms after each source switch
// R12 - sixteen per-channel enables choose which inputs take the disconnect pulse
// R13 - one serial bit disconnects all input terminations at once
// R14 - input terminations are connected after reset
// R15 - under parallel control input terminations always stay connected
// R16 - each equalizer has two boost settings, 6 dB or 12 dB, one bit
// R17 - serial control sets each of eight equalizer levels individually
// R18 - parallel control sets all equalizer levels with one pin
// R19 - a parallel pin selects whether output terminations are connected
// R20 - at reset output termination takes the parallel pin value
// R21 - at reset output current level takes the parallel pin value
// R22 - parallel source select is two bits, low and high, choosing the link
// R23 - a serial setting takes effect when its write transfer completes
`timescale 1ns/1ns
module lsc_top #(
    parameter int unsigned TERM_PULSE_CYCLES = int'(lsc_pkg::TERM_PULSE_CYC_L)
) (
    input  wire logic                 I_CLK,
    input  wire logic                 I_RST_N,
    input  wire logic                 I_PSEL,
    input  wire logic                 I_PENABLE,
    input  wire logic                 I_PWRITE,
    input  wire logic [7:0]           I_PADDR,
    input  wire logic [31:0]          I_PWDATA,
    output logic      [31:0]          O_PRDATA,
    output logic                      O_PREADY,
    output logic                      O_PSLVERR,
    input  wire logic [1:0]           I_PIN_SOURCE_SELECT_BUS,
    input  wire logic                 I_PIN_EQ_LEVEL_GLOBAL,
    input  wire logic                 I_PIN_OUTPUT_TERM_SELECT,
    input  wire logic                 I_PIN_OUTPUT_CURRENT_LEVEL,
    input  wire logic [2:0]           I_PIN_SLAVE_ADDR,
    output lsc_pkg::lsc_route_type    O_HS_ROUTE,
    output lsc_pkg::lsc_route_type    O_AUX_ROUTE,
    output logic      [15:0]          O_INPUT_TERM_CONNECT,
    output logic      [7:0]           O_INPUT_EQ_LEVEL_SELECT,
    output logic                      O_OUTPUT_TERM_ENABLE,
    output logic                      O_OUTPUT_CURRENT_LEVEL,
    output logic                      O_SERIAL_CONTROL
);
    import lsc_pkg::*;

    localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(TERM_PULSE_CYCLES);

    lsc_state_type st;
    lsc_state_type next_st;
    lsc_pins_type  pins_in;
    lsc_route_type hs_route;
    lsc_route_type aux_route;
    logic          hit;
    logic          done;
    logic [4:0]    ofs;
    logic          mapped;
    logic [31:0]   rd_word;
    logic [15:0]   term_conn;

    // same mapping for every output lane, so any lane may carry the clock
    function automatic lsc_route_type route_of(input lsc_mode_type mode, input logic [3:0] chan);
        lsc_route_type r;
        r = '0;
        for (int c = 0; c < NUM_OUTPUTS; c++) begin
            case (mode)
                MODE_DUAL:   r[c*4 +: 4] = {chan[2:0], c[0]};          // [R2]
                MODE_SINGLE: r[c*4 +: 4] = chan;                       // [R2]
                default:     r[c*4 +: 4] = {chan[1:0], c[1:0]};        // [R1] [R3]
            endcase
        end
        return r;
    endfunction

    assign pins_in = '{
        src_sel:    I_PIN_SOURCE_SELECT_BUS,
        eq_level:   I_PIN_EQ_LEVEL_GLOBAL,
        out_term:   I_PIN_OUTPUT_TERM_SELECT,
        out_cur:    I_PIN_OUTPUT_CURRENT_LEVEL,
        slave_addr: I_PIN_SLAVE_ADDR
    };

    // effective routing: pins in parallel mode, registers once serial took over
    always_comb begin
        if (st.serial_locked) begin                                    // [R4] [R8]
            hs_route  = route_of(st.cfg.hs_mode, st.cfg.hs_chan);      // [R9]
            aux_route = route_of(st.cfg.aux_mode, st.cfg.aux_chan);    // [R9]
        end else begin
            hs_route  = route_of(MODE_QUAD, {2'b00, st.pin_sync.src_sel}); // [R10] [R22]
            aux_route = route_of(MODE_QUAD, {2'b00, st.pin_sync.src_sel}); // [R10]
        end
    end

    // terminations: parallel mode keeps them all on
    always_comb begin
        if (!st.serial_locked) begin
            term_conn = '1;                                            // [R15] [R14]
        end else if (st.cfg.term_global_off) begin
            term_conn = '0;                                            // [R13]
        end else if (st.pulse_cnt != '0) begin
            term_conn = ~st.cfg.term_pulse_en;                         // [R11] [R12]
        end else begin
            term_conn = '1;
        end
    end

    assign ofs    = I_PADDR[4:0];
    assign hit    = I_PSEL && (I_PADDR[7:5] == st.pin_sync.slave_addr); // [R5]
    assign done   = hit && I_PENABLE;

    always_comb begin
        mapped  = 1'b1;
        rd_word = '0;
        case (ofs)
            OFS_HS_MODE: begin
                rd_word[MODE_POS +: 2] = st.cfg.hs_mode;
                rd_word[CHAN_POS +: 4] = st.cfg.hs_chan;
            end
            OFS_AUX_MODE: begin
                rd_word[MODE_POS +: 2] = st.cfg.aux_mode;
                rd_word[CHAN_POS +: 4] = st.cfg.aux_chan;
            end
            OFS_RX_SETTINGS: begin
                rd_word[TERM_OFF_POS] = st.cfg.term_global_off;
            end
            OFS_TERM_PULSE: begin
                rd_word[15:0] = st.cfg.term_pulse_en;
            end
            OFS_INPUT_EQ_LEVEL_SELECT: begin
                rd_word[NUM_EQ-1:0] = st.cfg.eq_level;
            end
            OFS_TX_SETTINGS: begin
                rd_word[TX_TERM_POS] = st.cfg.tx_term;
                rd_word[TX_OCL_POS]  = st.cfg.tx_ocl;
            end
            OFS_STATUS: begin
                rd_word[ST_LOCK_POS]              = st.serial_locked;
                rd_word[ST_PULSE_POS]             = (st.pulse_cnt != '0);
                rd_word[ST_CONN_POS +: ST_CONN_W] = term_conn;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_st          = st;
        next_st.pin_meta = pins_in;
        next_st.pin_sync = st.pin_meta;

        // output termination and current level follow straps after reset and while under parallel control
        if (st.strap_pending) begin
            next_st.cfg.tx_term   = st.pin_sync.out_term;              // [R20]
            next_st.cfg.tx_ocl    = st.pin_sync.out_cur;               // [R21]
            next_st.strap_pending = 1'b0;
        end else if (!st.serial_locked) begin
            next_st.cfg.tx_term   = st.pin_sync.out_term;              // [R19]
            next_st.cfg.tx_ocl    = st.pin_sync.out_cur;
        end

        // read data is captured in the setup cycle, shown in the access cycle
        if (hit && !I_PENABLE) begin
            next_st.prdata  = I_PWRITE ? 32'h0000_0000 : rd_word;
            next_st.pslverr = !mapped;
        end else if (!I_PSEL) begin
            next_st.prdata  = 32'h0000_0000;
            next_st.pslverr = 1'b0;
        end

        if (done) begin
            next_st.serial_locked = 1'b1;                              // [R8]
            if (!st.serial_locked) begin
                // serial control starts from what the pins had set
                next_st.cfg.hs_chan  = {2'b00, st.pin_sync.src_sel};
                next_st.cfg.aux_chan = {2'b00, st.pin_sync.src_sel};
                next_st.cfg.eq_level = {NUM_EQ{st.pin_sync.eq_level}};
            end
            if (I_PWRITE) begin                                        // [R23] [R7]
                case (ofs)
                    OFS_HS_MODE: begin
                        next_st.cfg.hs_mode = lsc_mode_type'(I_PWDATA[MODE_POS +: 2]);
                        next_st.cfg.hs_chan = I_PWDATA[CHAN_POS +: 4];
                    end
                    OFS_AUX_MODE: begin
                        next_st.cfg.aux_mode = lsc_mode_type'(I_PWDATA[MODE_POS +: 2]);
                        next_st.cfg.aux_chan = I_PWDATA[CHAN_POS +: 4];
                    end
                    OFS_RX_SETTINGS: begin
                        next_st.cfg.term_global_off = I_PWDATA[TERM_OFF_POS]; // [R13]
                    end
                    OFS_TERM_PULSE: begin
                        next_st.cfg.term_pulse_en = I_PWDATA[15:0];    // [R12]
                    end
                    OFS_INPUT_EQ_LEVEL_SELECT: begin
                        next_st.cfg.eq_level = I_PWDATA[NUM_EQ-1:0];   // [R16] [R17]
                    end
                    OFS_TX_SETTINGS: begin
                        next_st.cfg.tx_term = I_PWDATA[TX_TERM_POS];
                        next_st.cfg.tx_ocl  = I_PWDATA[TX_OCL_POS];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // every change of the link routing restarts the disconnect pulse
        next_st.last_route = hs_route;
        if (hs_route != st.last_route) begin
            next_st.pulse_cnt = PULSE_LOAD;                            // [R11]
        end else if (st.pulse_cnt != '0) begin
            next_st.pulse_cnt = st.pulse_cnt - PULSE_CNT_W'(1);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            st                <= '0;                                   // [R6]
            st.cfg            <= CFG_RESET;                            // [R6] [R14]
            st.strap_pending  <= 1'b1;
            st.last_route     <= route_of(MODE_QUAD, 4'h0);
            st.pin_meta       <= next_st.pin_meta;
            st.pin_sync       <= next_st.pin_sync;
        end else begin
            st <= next_st;
        end
    end

    assign O_PRDATA                = st.prdata;
    assign O_PREADY                = 1'b1;
    assign O_PSLVERR               = st.pslverr && I_PSEL && I_PENABLE;
    assign O_HS_ROUTE              = hs_route;
    assign O_AUX_ROUTE             = aux_route;
    assign O_INPUT_TERM_CONNECT    = term_conn;
    assign O_INPUT_EQ_LEVEL_SELECT = st.serial_locked ? st.cfg.eq_level
                                                      : {NUM_EQ{st.pin_sync.eq_level}}; // [R18]
    assign O_OUTPUT_TERM_ENABLE    = st.cfg.tx_term;
    assign O_OUTPUT_CURRENT_LEVEL  = st.cfg.tx_ocl;
    assign O_SERIAL_CONTROL        = st.serial_locked;

endmodule // lsc_top

// ---- lsc_top_dummy_none.sv ----
`timescale 1ns/1ns

// ---- lsc_chk.sv ----
`timescale 1ns/1ns
module lsc_chk
    import lsc_pkg::*;
(
    input wire logic          I_CLK,
    input wire logic          I_RST_N,
    input wire logic          I_PSEL,
    input wire logic          I_PENABLE,
    input wire logic          I_PWRITE,
    input wire logic [7:0]    I_PADDR,
    input wire logic [31:0]   I_PWDATA,
    input wire logic          O_PREADY,
    input wire logic          O_PSLVERR,
    input wire logic [1:0]    I_PIN_SOURCE_SELECT_BUS,
    input wire logic          I_PIN_EQ_LEVEL_GLOBAL,
    input wire logic          I_PIN_OUTPUT_TERM_SELECT,
    input wire logic          I_PIN_OUTPUT_CURRENT_LEVEL,
    input wire logic [2:0]    I_PIN_SLAVE_ADDR,
    input wire lsc_route_type O_HS_ROUTE,
    input wire lsc_route_type O_AUX_ROUTE,
    input wire logic [15:0]   O_INPUT_TERM_CONNECT,
    input wire logic [7:0]    O_INPUT_EQ_LEVEL_SELECT,
    input wire logic          O_OUTPUT_TERM_ENABLE,
    input wire logic          O_OUTPUT_CURRENT_LEVEL,
    input wire logic          O_SERIAL_CONTROL
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    logic       acc;
    logic [1:0] q;
    assign acc = I_PSEL && I_PENABLE;
    assign q   = O_HS_ROUTE[3:2];
    a_ready_always: assert property (O_PREADY) else $error("pready low");
    a_err_access: assert property (O_PSLVERR |-> acc) else $error("error outside access");
    a_lock_sticky: assert property (O_SERIAL_CONTROL |=> O_SERIAL_CONTROL) else $error("lock lost");
    a_par_term_on: assert property (!O_SERIAL_CONTROL |-> O_INPUT_TERM_CONNECT == 16'hFFFF)
        else $error("term off in pin mode");
    a_par_quad: assert property (!O_SERIAL_CONTROL |-> O_AUX_ROUTE == O_HS_ROUTE
        && O_HS_ROUTE == {q, 2'd3, q, 2'd2, q, 2'd1, q, 2'd0}) else $error("pin mode not quad");
    a_pin_follow: assert property ((!O_SERIAL_CONTROL && $stable(I_PIN_SOURCE_SELECT_BUS)
        && $stable(I_PIN_EQ_LEVEL_GLOBAL))[*3] |-> q == I_PIN_SOURCE_SELECT_BUS
        && O_INPUT_EQ_LEVEL_SELECT == {8{I_PIN_EQ_LEVEL_GLOBAL}}) else $error("pins not followed");
    a_tx_pins: assert property ((!O_SERIAL_CONTROL && $stable(I_PIN_OUTPUT_TERM_SELECT)
        && $stable(I_PIN_OUTPUT_CURRENT_LEVEL))[*5] |-> O_OUTPUT_TERM_ENABLE == I_PIN_OUTPUT_TERM_SELECT
        && O_OUTPUT_CURRENT_LEVEL == I_PIN_OUTPUT_CURRENT_LEVEL) else $error("tx pins");
    a_eq_write: assert property (acc && I_PWRITE && I_PADDR == {I_PIN_SLAVE_ADDR, OFS_INPUT_EQ_LEVEL_SELECT}
        |=> O_INPUT_EQ_LEVEL_SELECT == $past(I_PWDATA[7:0]) && O_SERIAL_CONTROL) else $error("eq write");
    a_global_off: assert property (acc && I_PWRITE && I_PWDATA[0] && I_PADDR == {I_PIN_SLAVE_ADDR,
        OFS_RX_SETTINGS} |=> O_INPUT_TERM_CONNECT == 16'h0000) else $error("global off");
    a_foreign_addr: assert property (acc && I_PADDR[7:5] != I_PIN_SLAVE_ADDR && !O_SERIAL_CONTROL
        |=> !O_SERIAL_CONTROL) else $error("foreign address locked");
    cover property (acc && O_PSLVERR);
    cover property ($rose(O_SERIAL_CONTROL));
    cover property (O_SERIAL_CONTROL && O_INPUT_TERM_CONNECT == 16'hFFFA);
endmodule // lsc_chk

// ---- lsc_host.sv ----
`timescale 1ns/1ns
module lsc_host (
    input  wire logic        i_clk,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr
);
    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0;
    end
    // request held until pready is seen high at an edge; answer taken at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        logic r;
        @(posedge i_clk);
        o_psel    <= 1'b1;
        o_pwrite  <= w;
        o_paddr   <= a;
        o_pwdata  <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        r = 1'b0;
        while (r !== 1'b1) begin
            @(posedge i_clk);
            r = i_pready;
        end
        q = i_prdata;
        e = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule // lsc_host

// ---- link_switch_control_logic_test.sv ----
`timescale 1ns/1ns
module link_switch_control_logic_test;
    import lsc_pkg::*;
    localparam logic [2:0] SLV = 3'h5;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          psel, penable, pwrite, pready, pslverr, e, ote, ocl_o, sc;
    logic [7:0]    paddr, eq;
    logic [31:0]   pwdata, prdata, q;
    logic [1:0]    sel = 2'b00;
    logic          eq_pin = 1'b0;
    logic          ot = 1'b1;
    logic          ocl = 1'b1;
    lsc_route_type hs, aux;
    logic [15:0]   term;
    int            n_errors = 0;
    int            comparisons = 0;
    always #5 clk = ~clk;
    lsc_top #(.TERM_PULSE_CYCLES(20)) DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_PIN_SOURCE_SELECT_BUS(sel), .I_PIN_EQ_LEVEL_GLOBAL(eq_pin),
        .I_PIN_OUTPUT_TERM_SELECT(ot), .I_PIN_OUTPUT_CURRENT_LEVEL(ocl), .I_PIN_SLAVE_ADDR(SLV),
        .O_HS_ROUTE(hs), .O_AUX_ROUTE(aux), .O_INPUT_TERM_CONNECT(term), .O_INPUT_EQ_LEVEL_SELECT(eq),
        .O_OUTPUT_TERM_ENABLE(ote), .O_OUTPUT_CURRENT_LEVEL(ocl_o), .O_SERIAL_CONTROL(sc));
    lsc_host host (.i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    function automatic lsc_route_type route(input logic [1:0] m, input logic [3:0] c);
        for (int l = 0; l < 4; l++)
            route[l*4 +: 4] = (m == 2'd2) ? c : (m == 2'd1) ? {c[2:0], l[0]} : {c[1:0], l[1:0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [4:0] o, input logic [31:0] d);
        host.xfer(1'b1, {SLV, o}, d, q, e);
        cyc(1);
    endtask
    task automatic rd(input logic [4:0] o);
        host.xfer(1'b0, {SLV, o}, 32'h0, q, e);
        cyc(1);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        chk({sc, term, ote, ocl_o}, {1'b0, 16'hFFFF, 2'b11}, "after reset");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            sel    <= s[1:0];
            eq_pin <= s[0];
            ot     <= s[1];
            ocl    <= ~s[1];
            cyc(5);
            chk({hs, aux}, {route(2'd0, {2'b00, sel}), route(2'd0, {2'b00, sel})}, "pin route");
            chk({eq, ote, ocl_o}, {{8{eq_pin}}, ot, ocl}, "pin eq tx");
        end
        host.xfer(1'b1, {~SLV, OFS_INPUT_EQ_LEVEL_SELECT}, 32'hFF, q, e);
        cyc(1);
        chk({sc, eq}, {1'b0, 8'hFF}, "foreign address");
        $display("test parallel done");
        wr(OFS_INPUT_EQ_LEVEL_SELECT, 32'hA5);
        chk({sc, eq}, {1'b1, 8'hA5}, "eq write");
        @(posedge clk);
        sel    <= 2'b00;
        eq_pin <= 1'b0;
        cyc(5);
        chk({hs, eq}, {route(2'd0, 4'h3), 8'hA5}, "pins ignored");
        for (int m = 0; m < 3; m++) begin
            wr(OFS_HS_MODE, {24'h0, 4'hB ^ m[3:0], 2'b00, m[1:0]});
            chk(hs, route(m[1:0], 4'hB ^ m[3:0]), "serial mode");
        end
        wr(OFS_AUX_MODE, 32'h22);
        chk({aux, hs}, {route(2'd2, 4'h2), route(2'd2, 4'h9)}, "aux independent");
        wr(OFS_TERM_PULSE, 32'h5);
        wr(OFS_HS_MODE, 32'h10);
        cyc(2);
        chk(term, 16'hFFFA, "pulse active");
        cyc(25);
        chk(term, 16'hFFFF, "pulse over");
        wr(OFS_RX_SETTINGS, 32'h1);
        chk(term, 16'h0000, "global off");
        wr(OFS_TX_SETTINGS, 32'h2);
        chk({ote, ocl_o}, 2'b01, "tx serial");
        rd(5'h1C);
        chk({e, q}, 33'h1_0000_0000, "unmapped");
        rd(OFS_STATUS);
        chk(q[0], 1'b1, "status lock");
        $display("test serial done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        chk({sc, term, eq, ote, ocl_o}, {1'b0, 16'hFFFF, 8'h00, ot, ocl}, "second reset");
        $display("test reset done");
        summarize();
    end
endmodule // link_switch_control_logic_test
bind lsc_top lsc_chk u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_PIN_SOURCE_SELECT_BUS(I_PIN_SOURCE_SELECT_BUS), .I_PIN_EQ_LEVEL_GLOBAL(I_PIN_EQ_LEVEL_GLOBAL),
    .I_PIN_OUTPUT_TERM_SELECT(I_PIN_OUTPUT_TERM_SELECT), .I_PIN_OUTPUT_CURRENT_LEVEL(I_PIN_OUTPUT_CURRENT_LEVEL),
    .I_PIN_SLAVE_ADDR(I_PIN_SLAVE_ADDR), .O_HS_ROUTE(O_HS_ROUTE), .O_AUX_ROUTE(O_AUX_ROUTE),
    .O_INPUT_TERM_CONNECT(O_INPUT_TERM_CONNECT), .O_INPUT_EQ_LEVEL_SELECT(O_INPUT_EQ_LEVEL_SELECT),
    .O_OUTPUT_TERM_ENABLE(O_OUTPUT_TERM_ENABLE), .O_OUTPUT_CURRENT_LEVEL(O_OUTPUT_CURRENT_LEVEL),
    .O_SERIAL_CONTROL(O_SERIAL_CONTROL));
